//--- logic/iio_irq_logic.sv
// interrupt enable, latched event flags and serial register port
// Operation
// - enabled latched flag raises interrupt, unless sample bit is set
// - sample enable gives interrupts every ADC sample
// - reset completion flag, enable defaults one
// - cool-down entry sets flag bit 11
// - thermal load shutdown sets flag bit 10
// - isolation link error sets bit 9
// - shadow register mismatch sets bit 8
// - warning comparator rising edges set bits 1-3
// - filtered output rising edge sets bit 0
// - flag register latches events regardless of enable
// - writing one clears flag, zero keeps
// - flag clears accepted while locked
// - reset loads enable 0x4000, flags zero
// - comparator sets above high, clears at low
// - live status register shows unlatched conditions
`timescale 1ns/1ps
module iio_irq_logic #(
	parameter int CLK_HZ = iio_pkg::CLK_HZ,
	parameter int SAMPLE_HZ = iio_pkg::SAMPLE_HZ
) (
	// core clock and control
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic LOCKED,
	// event sources and comparator inputs
	input wire iio_pkg::iio_src_t EVENTS,
	input wire logic [7:0] ADC_SAMPLE,
	input wire iio_pkg::iio_thr_t WARN_HI_THR,
	input wire iio_pkg::iio_thr_t WARN_LO_THR,
	// serial register port
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic MOSI,
	output logic MISO,
	output logic MISO_OE,
	// interrupt and sample timing
	output logic IRQ_N,
	output logic ADC_SAMPLE_STROBE
);

	// ****************************************
	// derived timing
	// ****************************************
	localparam int SAMPLE_CYCLES = (CLK_HZ / SAMPLE_HZ) < 1 ? 1 : CLK_HZ / SAMPLE_HZ;
	localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_CYCLES - 1);

	// ****************************************
	// link domain: frame shifter
	// ****************************************
	logic [5:0] bit_cnt;
	logic [15:0] in_sh;
	logic [15:0] out_sh;
	logic hdr_wr;
	logic [11:0] hdr_addr;
	logic hdr_tog;
	logic wr_tog;
	logic [11:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_hold;
	wire [15:0] word_in = {in_sh[14:0], MOSI};
	wire hdr_end = bit_cnt == iio_pkg::CNT_HDR_END;
	wire data_end = bit_cnt == iio_pkg::CNT_DATA_END;
	wire turn_end = bit_cnt == iio_pkg::CNT_TURN_END;
	wire data_out = bit_cnt > iio_pkg::CNT_TURN_END && bit_cnt <= iio_pkg::CNT_DATA_END;

	// the frame counter is cleared by chip select, so a stopped clock is harmless
	always_ff @(posedge SCLK, posedge RESET, posedge CS_N) begin
		if (RESET) begin
			bit_cnt <= 6'h00;
		end else if (CS_N) begin
			bit_cnt <= 6'h00;
		end else if (bit_cnt != iio_pkg::CNT_FULL) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end

	always_ff @(posedge SCLK, posedge RESET) begin
		if (RESET) begin
			in_sh <= 16'h0000;
			hdr_wr <= 1'b0;
			hdr_addr <= 12'h000;
			hdr_tog <= 1'b0;
			wr_tog <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 16'h0000;
		end else begin
			in_sh <= word_in;
			if (hdr_end) begin
				hdr_wr <= word_in[iio_pkg::HDR_WR_BIT];
				hdr_addr <= word_in[11:0];
				hdr_tog <= ~hdr_tog;
			end
			if (data_end && hdr_wr) begin
				wr_addr <= hdr_addr;
				wr_data <= word_in;
				wr_tog <= ~wr_tog;
			end
		end
	end

	// rd_hold settles within a few core cycles of the header toggle, long before
	// the turnaround ends; this bounds the fastest usable serial clock
	always_ff @(negedge SCLK, posedge RESET, posedge CS_N) begin
		if (RESET) begin
			MISO <= 1'b0;
			MISO_OE <= 1'b0;
			out_sh <= 16'h0000;
		end else if (CS_N) begin
			MISO <= 1'b0;
			MISO_OE <= 1'b0;
			out_sh <= 16'h0000;
		end else begin
			MISO_OE <= 1'b1;
			if (turn_end) begin
				MISO <= rd_hold[15];
				out_sh <= {rd_hold[14:0], 1'b0};
			end else if (data_out) begin
				MISO <= out_sh[15];
				out_sh <= {out_sh[14:0], 1'b0};
			end else begin
				MISO <= 1'b0;
			end
		end
	end

	// ****************************************
	// crossing: toggles into the core domain
	// ****************************************
	logic [2:0] hdr_s;
	logic [2:0] wr_s;
	wire hdr_fire = hdr_s[2] ^ hdr_s[1];
	wire wr_fire = wr_s[2] ^ wr_s[1];

	always_ff @(posedge CLK, posedge RESET) begin
		if (RESET) begin
			hdr_s <= 3'h0;
			wr_s <= 3'h0;
		end else if (CE) begin
			hdr_s <= {hdr_s[1:0], hdr_tog};
			wr_s <= {wr_s[1:0], wr_tog};
		end
	end

	// ****************************************
	// warning comparators with hysteresis
	// ****************************************
	logic [iio_pkg::NUM_WARN-1:0] warn;

	for (genvar g = 0; g < iio_pkg::NUM_WARN; g++) begin : g_warn
		always_ff @(posedge CLK, posedge RESET) begin
			if (RESET) begin
				warn[g] <= 1'b0;
			end else if (CE) begin
				if (ADC_SAMPLE > WARN_HI_THR[g]) begin
					warn[g] <= 1'b1;
				end else if (ADC_SAMPLE <= WARN_LO_THR[g]) begin
					warn[g] <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// event flags and enables
	// ****************************************
	logic [15:0] mask;
	logic [15:0] flags;
	logic [15:0] prev_live;
	logic [15:0] smp_cnt;
	wire [15:0] live = iio_pkg::iio_event_word(EVENTS, warn);
	// every source latches on its rising edge only
	wire [15:0] rise = live & ~prev_live & iio_pkg::FLAG_IMPL;
	wire wr_flags = wr_fire && wr_addr == iio_pkg::ADDR_FLAGS;
	// lock guards configuration only; acknowledges still go through
	wire wr_mask = wr_fire && wr_addr == iio_pkg::ADDR_MASK && !LOCKED;
	wire [15:0] clr = wr_flags ? wr_data : iio_pkg::DATA_ZERO;
	// a set in the clearing cycle wins, so no event is lost
	wire [15:0] next_flags = ((flags & ~clr) | rise) & iio_pkg::FLAG_IMPL;
	wire [15:0] next_mask = wr_mask ? wr_data : mask;
	wire irq_any = |(flags[14:0] & mask[14:0]);
	wire smp_wrap = smp_cnt == SAMPLE_LAST;
	wire [15:0] next_smp = smp_wrap ? 16'h0000 : smp_cnt + 16'h0001;
	// in sample mode the other enables are assumed zero and are not looked at
	wire next_irq_n = mask[iio_pkg::BIT_SAMPLE] ? ~smp_wrap : ~irq_any;
	wire sel_mask = hdr_addr == iio_pkg::ADDR_MASK;
	wire sel_flags = hdr_addr == iio_pkg::ADDR_FLAGS;
	wire sel_status = hdr_addr == iio_pkg::ADDR_STATUS;
	wire [15:0] next_rd = sel_mask ? mask : sel_flags ? flags : sel_status ? live : iio_pkg::DATA_ZERO;

	always_ff @(posedge CLK, posedge RESET) begin
		if (RESET) begin
			mask <= iio_pkg::MASK_RST;
			flags <= iio_pkg::FLAGS_RST;
			prev_live <= 16'h0000;
		end else if (CE) begin
			mask <= next_mask;
			flags <= next_flags;
			prev_live <= live;
		end
	end

	always_ff @(posedge CLK, posedge RESET) begin
		if (RESET) begin
			smp_cnt <= 16'h0000;
			ADC_SAMPLE_STROBE <= 1'b0;
			IRQ_N <= 1'b1;
		end else if (CE) begin
			smp_cnt <= next_smp;
			ADC_SAMPLE_STROBE <= smp_wrap;
			IRQ_N <= next_irq_n;
		end
	end

	// read word is taken once per frame, at the end of the header
	always_ff @(posedge CLK, posedge RESET) begin
		if (RESET) begin
			rd_hold <= 16'h0000;
		end else if (CE && hdr_fire) begin
			rd_hold <= next_rd;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	chk_irq_level_mode: assert property (CE && !mask[15] |=> IRQ_N == !$past(irq_any))
		else $error("level interrupt does not follow enabled flags");
	chk_irq_sample_mode: assert property (CE && mask[15] && smp_wrap |=> !IRQ_N && ADC_SAMPLE_STROBE)
		else $error("sample interrupt missing at sample strobe");
	chk_sample_quiet: assert property (CE && mask[15] && !smp_wrap |=> IRQ_N)
		else $error("interrupt outside sample strobe in sample mode");
	chk_event_latch: assert property (CE |=> (flags & $past(rise)) == $past(rise))
		else $error("event rise not latched");
	chk_dout_fall_quiet: assert property (CE && !flags[0] && !rise[0] |=> !flags[0])
		else $error("flag 0 set without rising edge");
	chk_reset_complete_flag: assert property (CE && EVENTS.reset_complete && !prev_live[14] |=> flags[14])
		else $error("reset completion not flagged");
	chk_w1c_clear: assert property (CE && wr_flags |=> (flags & $past(clr) & ~$past(rise)) == 16'h0000)
		else $error("write one did not clear flag");
	chk_w0_keep: assert property (CE && wr_flags |=>
		(flags & ~$past(clr) & $past(flags)) == (~$past(clr) & $past(flags)))
		else $error("write zero disturbed a flag");
	chk_locked_clear: assert property (CE && LOCKED && wr_flags |=>
		(flags & $past(clr) & ~$past(rise)) == 16'h0000)
		else $error("flag clear refused while locked");
	chk_locked_mask: assert property (CE && LOCKED |=> $stable(mask))
		else $error("enable register changed while locked");
	chk_warn_hyst: assert property (CE && ADC_SAMPLE > WARN_HI_THR[0] ##1
		CE && ADC_SAMPLE > WARN_LO_THR[0] |=> warn[0])
		else $error("warning comparator did not hold high");

	cov_sample_irq: cover property (mask[15] && !IRQ_N);
	cov_level_irq: cover property (!mask[15] && !IRQ_N ##[1:1000] IRQ_N);
	cov_locked_clear: cover property (LOCKED && wr_flags && (flags & clr) != 16'h0000);
	cov_warn_rise: cover property (rise[3:1] != 3'h0);

endmodule

//--- logic/iio_pkg.sv
// constants and types for the isolated input interrupt logic
package iio_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam logic [11:0] ADDR_MASK = 12'h00B;
	localparam logic [11:0] ADDR_FLAGS = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h00D;
	localparam logic [15:0] MASK_RST = 16'h4000;
	localparam logic [15:0] FLAGS_RST = 16'h0000;
	localparam logic [15:0] DATA_ZERO = 16'h0000;
	// flag bits that hardware can set; the rest stay zero
	localparam logic [15:0] FLAG_IMPL = 16'h6F0F;

	// ****************************************
	// bit positions
	// ****************************************
	localparam int BIT_SAMPLE = 15;
	localparam int BIT_RESET_COMPLETE = 14;
	localparam int BIT_BUSY = 13;
	localparam int BIT_COOL = 11;
	localparam int BIT_THERM = 10;
	localparam int BIT_LINK = 9;
	localparam int BIT_SHADOW = 8;
	localparam int BIT_WARN0 = 1;
	localparam int BIT_FILT = 0;
	localparam int NUM_WARN = 3;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 40000000;
	localparam int SAMPLE_HZ = 100000;

	// ****************************************
	// serial frame: 16 header, 8 turnaround, 16 data
	// ****************************************
	localparam int HDR_WR_BIT = 15;
	localparam logic [5:0] CNT_HDR_END = 6'h0F;
	localparam logic [5:0] CNT_TURN_END = 6'h18;
	localparam logic [5:0] CNT_DATA_END = 6'h27;
	localparam logic [5:0] CNT_FULL = 6'h28;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic reset_complete;
		logic busy;
		logic load_cooling_ch;
		logic thermal_cutoff;
		logic isolation_link_error;
		logic shadow_mismatch;
		logic filtered_input_out;
	} iio_src_t;

	typedef logic [NUM_WARN-1:0][7:0] iio_thr_t;

	function automatic logic [15:0] iio_event_word(input iio_src_t src, input logic [NUM_WARN-1:0] warn);
		logic [15:0] w;
		w = DATA_ZERO;
		w[BIT_RESET_COMPLETE] = src.reset_complete;
		w[BIT_BUSY] = src.busy;
		w[BIT_COOL] = src.load_cooling_ch;
		w[BIT_THERM] = src.thermal_cutoff;
		w[BIT_LINK] = src.isolation_link_error;
		w[BIT_SHADOW] = src.shadow_mismatch;
		w[BIT_WARN0 +: NUM_WARN] = warn;
		w[BIT_FILT] = src.filtered_input_out;
		return w;
	endfunction

endpackage

//--- verification/iio_host_model.sv
// host side serial master for the isolated input interrupt logic
`timescale 1ns/1ps
module iio_host_model (
	// serial link, driven by the host
	output logic SCLK,
	output logic CS_N,
	output logic MOSI,
	// serial link, driven by the device
	input wire logic MISO,
	input wire logic MISO_OE
);
	// ****************************************
	// frame engine
	// ****************************************
	// the clock stands low between frames; mosi changes only while sclk is low
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		MOSI = 1'b0;
	end

	task automatic frame(input logic wr, input logic [11:0] addr, input logic [15:0] wdata,
		output logic [15:0] rdata);
		logic [39:0] sh;
		sh = {wr, 3'h0, addr, 8'h00, wdata};
		rdata = 16'h0000;
		CS_N = 1'b0;
		for (int i = 39; i >= 0; i--) begin
			MOSI = sh[i];
			#80;
			SCLK = 1'b1;
			// an undriven line is read as the inverse of mosi, never as the old value
			if (i < 16) begin
				rdata = {rdata[14:0], MISO_OE ? MISO : ~MOSI};
			end
			#80;
			SCLK = 1'b0;
		end
		#80;
		CS_N = 1'b1;
		#160;
	endtask
endmodule

//--- verification/isolated_input_irq_logic_bench.sv
// self-checking bench for the isolated input interrupt logic
`timescale 1ns/1ps
module isolated_input_irq_logic_bench;
	// ****************************************
	// signals
	// ****************************************
	logic CLK, RESET, CE, LOCKED, SCLK, CS_N, MOSI, MISO, MISO_OE, IRQ_N, ADC_SAMPLE_STROBE;
	iio_pkg::iio_src_t EVENTS;
	logic [7:0] ADC_SAMPLE;
	logic [15:0] acc, n, bad;
	int err_count, checks_done, cycles;
	int flag_bit [6] = '{0, 8, 9, 10, 11, 13};

	// short sample period keeps the sample-mode run brief: one strobe every 8 cycles
	iio_irq_logic #(.CLK_HZ(iio_pkg::CLK_HZ), .SAMPLE_HZ(iio_pkg::CLK_HZ / 8)) dut_u (.CLK(CLK), .RESET(RESET),
		.CE(CE), .LOCKED(LOCKED), .EVENTS(EVENTS), .ADC_SAMPLE(ADC_SAMPLE), .WARN_HI_THR({3{8'h80}}),
		.WARN_LO_THR({3{8'h40}}), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE),
		.IRQ_N(IRQ_N), .ADC_SAMPLE_STROBE(ADC_SAMPLE_STROBE));
	iio_host_model host_u (.SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		logic [15:0] junk;
		host_u.frame(1'b1, a, v, junk);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		logic [15:0] d;
		host_u.frame(1'b0, a, 16'h0000, d);
		check(d, e);
	endtask

	task automatic settle;
		repeat (4) @(posedge CLK);
	endtask

	task automatic complete_run;
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************************************
	// clock and timeout
	// ****************************************
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	initial begin
		cycles = 0;
		forever begin
			@(posedge CLK);
			cycles++;
			if (cycles == 20000) begin
				err_count++;
				complete_run;
			end
		end
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		RESET = 1'b1;
		CE = 1'b1;
		LOCKED = 1'b0;
		EVENTS = '0;
		ADC_SAMPLE = 8'h00;
		err_count = 0;
		checks_done = 0;
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		settle;
		rdc(iio_pkg::ADDR_MASK, iio_pkg::MASK_RST);
		rdc(iio_pkg::ADDR_FLAGS, iio_pkg::FLAGS_RST);
		check({15'h0000, IRQ_N}, 16'h0001);
		@(posedge CLK);
		EVENTS.reset_complete <= 1'b1;
		settle;
		check({15'h0000, IRQ_N}, 16'h0000);
		rdc(iio_pkg::ADDR_FLAGS, 16'h4000);
		wr(iio_pkg::ADDR_FLAGS, 16'h4000);
		check({15'h0000, IRQ_N}, 16'h0001);
		rdc(iio_pkg::ADDR_FLAGS, 16'h0000);
		wr(iio_pkg::ADDR_MASK, 16'h0000);
		acc = 16'h0000;
		for (int k = 0; k < 6; k++) begin
			@(posedge CLK);
			EVENTS[k] <= 1'b1;
			acc[flag_bit[k]] = 1'b1;
			settle;
			rdc(iio_pkg::ADDR_FLAGS, acc);
		end
		check({15'h0000, IRQ_N}, 16'h0001);
		wr(iio_pkg::ADDR_FLAGS, 16'h0000);
		rdc(iio_pkg::ADDR_FLAGS, acc);
		// clear flag 0 first so that a flag set by a falling edge would show
		wr(iio_pkg::ADDR_FLAGS, 16'h0001);
		acc[0] = 1'b0;
		@(posedge CLK);
		EVENTS <= '0;
		settle;
		rdc(iio_pkg::ADDR_FLAGS, acc);
		@(posedge CLK);
		LOCKED <= 1'b1;
		wr(iio_pkg::ADDR_MASK, 16'h0F00);
		wr(iio_pkg::ADDR_FLAGS, 16'h0F00);
		acc = acc & ~16'h0F00;
		rdc(iio_pkg::ADDR_FLAGS, acc);
		rdc(iio_pkg::ADDR_MASK, 16'h0000);
		@(posedge CLK);
		LOCKED <= 1'b0;
		wr(iio_pkg::ADDR_MASK, 16'h2000);
		check({15'h0000, IRQ_N}, 16'h0000);
		// a link error that comes back makes the host rewrite its setup
		@(posedge CLK);
		EVENTS.isolation_link_error <= 1'b1;
		settle;
		rdc(iio_pkg::ADDR_FLAGS, acc | 16'h0200);
		wr(iio_pkg::ADDR_MASK, 16'h0001);
		wr(iio_pkg::ADDR_FLAGS, 16'hFFFF);
		rdc(iio_pkg::ADDR_FLAGS, 16'h0000);
		check({15'h0000, IRQ_N}, 16'h0001);
		@(posedge CLK);
		ADC_SAMPLE <= 8'h90;
		settle;
		rdc(iio_pkg::ADDR_FLAGS, 16'h000E);
		wr(iio_pkg::ADDR_FLAGS, 16'h000E);
		@(posedge CLK);
		ADC_SAMPLE <= 8'h60;
		settle;
		rdc(iio_pkg::ADDR_FLAGS, 16'h0000);
		@(posedge CLK);
		ADC_SAMPLE <= 8'h40;
		settle;
		ADC_SAMPLE <= 8'h90;
		settle;
		rdc(iio_pkg::ADDR_FLAGS, 16'h000E);
		rdc(iio_pkg::ADDR_STATUS, 16'h020E);
		rdc(12'h0FF, 16'h0000);
		// an input pulse while the clock enable is low must leave no trace
		@(posedge CLK);
		CE <= 1'b0;
		EVENTS.filtered_input_out <= 1'b1;
		settle;
		EVENTS.filtered_input_out <= 1'b0;
		settle;
		CE <= 1'b1;
		settle;
		rdc(iio_pkg::ADDR_FLAGS, 16'h000E);
		check({15'h0000, IRQ_N}, 16'h0001);
		wr(iio_pkg::ADDR_MASK, 16'h8000);
		n = 16'h0000;
		bad = 16'h0000;
		repeat (80) begin
			@(posedge CLK);
			#1;
			if (IRQ_N === 1'b0) n++;
			if (IRQ_N === ADC_SAMPLE_STROBE) bad++;
		end
		check(n, 16'h000A);
		check(bad, 16'h0000);
		complete_run;
	end
endmodule
